/* uep_params.svh */
// timing and size constants for the eprom programmer controller
`ifndef UEP_PARAMS_SVH
`define UEP_PARAMS_SVH
`define UEP_CLK_NS 25
`define UEP_SETUP_NS 10000
`define UEP_HOLD_NS 1000
`define UEP_READ_DELAY_NS 10000
`define UEP_ACCESS_NS 450
`define UEP_TOTAL_US 100000
`define UEP_PW_MIN_US 100
`define UEP_PW_MAX_US 1000
`define UEP_SETUP_CYC ((`UEP_SETUP_NS + `UEP_CLK_NS - 1) / `UEP_CLK_NS)
`define UEP_HOLD_CYC ((`UEP_HOLD_NS + `UEP_CLK_NS - 1) / `UEP_CLK_NS)
`define UEP_READ_DELAY_CYC ((`UEP_READ_DELAY_NS + `UEP_CLK_NS - 1) / `UEP_CLK_NS)
`define UEP_ACCESS_CYC ((`UEP_ACCESS_NS + `UEP_CLK_NS - 1) / `UEP_CLK_NS)
`define UEP_PW_DEFAULT_CYC ((`UEP_PW_MAX_US * 1000) / `UEP_CLK_NS)
`define UEP_LOOPS_DEFAULT 100
`define UEP_WORDS 1024
`define UEP_ADDR_W 10
`define UEP_CNT_W 16
`define UEP_LOOP_W 12
`define UEP_ZERO_BYTE 8'h00
`endif

/* uep_pkg.sv */
// types for the eprom programmer controller
`include "uep_params.svh"
package uep_pkg;
    typedef enum logic [3:0] {
        UEP_IDLE, UEP_RD_SETUP, UEP_RD_WAIT, UEP_PG_ENTER, UEP_PG_SETUP, UEP_PG_PULSE,
        UEP_PG_HOLD, UEP_PG_EXIT, UEP_PG_RECOVER
    } uep_state_e;
    // pins toward the memory
    typedef struct packed {
        logic [`UEP_ADDR_W-1:0] addr;
        logic [7:0] data;
        logic data_oe;
        logic select_n;
        logic select_program_high_level;
        logic program_pulse;
    } uep_pins_s;
    // whole controller state
    typedef struct packed {
        uep_state_e state;
        uep_pins_s pins;
        logic [`UEP_CNT_W-1:0] timer;
        logic [`UEP_LOOP_W-1:0] loop;
        logic [7:0] rdata;
        logic done;
    } uep_state_s;
endpackage

/* uep_programmer.sv */
// host controller that reads and programs a uv erasable byte-wide prom
`timescale 1ns/10ps
`default_nettype none
module uep_programmer import uep_pkg::*; #(
    parameter int WORDS = `UEP_WORDS,
    parameter int PULSE_CYC = `UEP_PW_DEFAULT_CYC,
    parameter int LOOPS = `UEP_LOOPS_DEFAULT,
    parameter int PW_MIN_CYC = (`UEP_PW_MIN_US * 1000) / `UEP_CLK_NS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic read_req_in,
    input wire logic [`UEP_ADDR_W-1:0] read_addr_in,
    input wire logic prog_req_in,
    input wire logic [7:0] image_data_in,
    output logic [`UEP_ADDR_W-1:0] image_addr_out,
    output logic [7:0] read_data_out,
    output logic busy_out,
    output logic done_out,
    output logic [`UEP_ADDR_W-1:0] mem_addr_out,
    output logic [7:0] mem_data_out,
    output logic mem_data_oe_out,
    input wire logic [7:0] mem_data_in,
    output logic mem_select_n_out,
    output logic select_program_high_level_out,
    output logic program_pulse_out
);
    // time-zero checks on the programming budget
    // words: 1024 or 512 for real parts, any smaller count serves a short bench run
    initial begin
        if (WORDS < 1 || WORDS > `UEP_WORDS) $error("word count out of range");
        if (PULSE_CYC < 1 || PULSE_CYC >= (1 << `UEP_CNT_W)) $error("pulse count out of range");
        if (PULSE_CYC < PW_MIN_CYC) $error("pulse shorter than the minimum width");
        if (LOOPS < 1 || LOOPS >= (1 << `UEP_LOOP_W)) $error("loop count out of range");
    end
    localparam logic [`UEP_CNT_W-1:0] PULSE_T = `UEP_CNT_W'(PULSE_CYC);
    localparam logic [`UEP_CNT_W-1:0] SETUP_T = `UEP_CNT_W'(`UEP_SETUP_CYC);
    localparam logic [`UEP_CNT_W-1:0] HOLD_T = `UEP_CNT_W'(`UEP_HOLD_CYC);
    localparam logic [`UEP_CNT_W-1:0] RDLY_T = `UEP_CNT_W'(`UEP_READ_DELAY_CYC);
    localparam logic [`UEP_CNT_W-1:0] ACC_T = `UEP_CNT_W'(`UEP_ACCESS_CYC);
    localparam logic [`UEP_LOOP_W-1:0] LAST_LOOP = `UEP_LOOP_W'(LOOPS - 1);
    localparam logic [`UEP_ADDR_W-1:0] LAST_ADDR = `UEP_ADDR_W'(WORDS - 1);
    uep_state_s cur; // registered state
    uep_state_s next_cur; // next state
    // sequence of one programming run
    // idle: a programming request wins over a read request
    // idle: the first address is zero and the loop count is zero
    // enter: the high program-enable level is raised
    // enter: the image byte for the current address is latched
    // enter: the data pins are driven toward the memory
    // setup: address, data and enable settle before the pulse
    // setup: the wait is a fixed count of clock cycles
    // pulse: the pulse pin stands high for the pulse count
    // pulse: address and data are not touched while it stands
    // hold: address and data stay after the pulse falls
    // hold: then the address steps on, or wraps to zero as the loop steps
    // exit: the high level falls first, the address later
    // exit: only after the hold time is the address moved
    // recover: the memory needs time before the first read
    // recover: done is pulsed once the wait is over
    //
    // sequence of one read
    // idle: the read address is taken with the request
    // idle: select is lowered, data pins are released
    // wait: the access time is counted in clock cycles
    // wait: the data pins are sampled when the count ends
    // wait: select rises again and done is pulsed
    //
    // hazards and limits
    // the image byte must be valid for the whole run
    // the image bus is read once per pulse, with no buffer
    // the loop count times pulse width is the caller's budget
    // a short pulse needs many more loops to reach the total
    // requests made while busy are dropped with no sign
    // the pulse pin is always driven low outside a pulse
    // a passive pull-down would let the pin creep upward
    // select stays high in programming so the memory never drives
    // the data pins are only driven while programming
    // a read never overlaps with the data pins driven
    //
    // timer use
    // one down-counter serves every wait of both sequences
    // a state does its work when the counter has run out
    // a load of n gives n idle cycles plus the working one
    // the pulse load is one less, so the pin stands n cycles
    //
    // loop use
    // the loop counter steps when the last address is passed
    // the run ends after the last address of the last loop
    // every pass sweeps all addresses in ascending order
    // no address sees a second pulse inside one pass
    //
    // done use
    // done is cleared by default on every cycle
    // it stands for exactly one cycle after each accepted request
    //
    // true when the address is the last one of a pass
    function automatic logic is_last_addr(input logic [`UEP_ADDR_W-1:0] a);
        return a == LAST_ADDR;
    endfunction
    // next-state logic
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        if (cur.timer != '0) begin
            next_cur.timer = cur.timer - 1'b1; // wait in place
        end else begin
            case (cur.state)
                UEP_IDLE: begin
                    if (prog_req_in) begin
                        next_cur.pins.addr = '0;
                        next_cur.loop = '0;
                        next_cur.pins.select_n = 1'b1; // keep memory off the data pins
                        next_cur.state = UEP_PG_ENTER;
                    end else if (read_req_in) begin
                        next_cur.pins.addr = read_addr_in;
                        next_cur.pins.select_n = 1'b0;
                        next_cur.pins.data_oe = 1'b0;
                        next_cur.timer = ACC_T;
                        next_cur.state = UEP_RD_WAIT;
                    end
                end
                UEP_RD_WAIT: begin
                    next_cur.rdata = mem_data_in;
                    next_cur.pins.select_n = 1'b1;
                    next_cur.done = 1'b1;
                    next_cur.state = UEP_IDLE;
                end
                UEP_PG_ENTER: begin
                    next_cur.pins.select_program_high_level = 1'b1;
                    next_cur.pins.data = image_data_in;
                    next_cur.pins.data_oe = 1'b1;
                    next_cur.timer = SETUP_T;
                    next_cur.state = UEP_PG_SETUP;
                end
                UEP_PG_SETUP: begin
                    next_cur.pins.program_pulse = 1'b1;
                    next_cur.timer = PULSE_T - 1'b1;
                    next_cur.state = UEP_PG_PULSE;
                end
                UEP_PG_PULSE: begin
                    next_cur.pins.program_pulse = 1'b0;
                    next_cur.timer = HOLD_T;
                    next_cur.state = UEP_PG_HOLD;
                end
                UEP_PG_HOLD: begin
                    if (is_last_addr(cur.pins.addr) && cur.loop == LAST_LOOP) begin
                        next_cur.pins.select_program_high_level = 1'b0;
                        next_cur.timer = HOLD_T;
                        next_cur.state = UEP_PG_EXIT;
                    end else begin
                        if (is_last_addr(cur.pins.addr)) begin
                            next_cur.pins.addr = '0;
                            next_cur.loop = cur.loop + 1'b1;
                        end else begin
                            next_cur.pins.addr = cur.pins.addr + 1'b1;
                        end
                        next_cur.state = UEP_PG_ENTER;
                    end
                end
                UEP_PG_EXIT: begin
                    next_cur.pins.data_oe = 1'b0;
                    next_cur.pins.addr = '0;
                    next_cur.timer = RDLY_T;
                    next_cur.state = UEP_PG_RECOVER;
                end
                UEP_PG_RECOVER: begin
                    next_cur.done = 1'b1;
                    next_cur.state = UEP_IDLE;
                end
                default: begin
                    next_cur.state = UEP_IDLE;
                end
            endcase
        end
    end
    // state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur <= '{state: UEP_IDLE, pins: '{addr: '0, data: `UEP_ZERO_BYTE, data_oe: 1'b0, select_n: 1'b1,
                     select_program_high_level: 1'b0, program_pulse: 1'b0},
                     timer: '0, loop: '0, rdata: `UEP_ZERO_BYTE, done: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end
    // outputs
    assign image_addr_out = cur.pins.addr;
    assign read_data_out = cur.rdata;
    assign busy_out = (cur.state != UEP_IDLE);
    assign done_out = cur.done;
    assign mem_addr_out = cur.pins.addr;
    assign mem_data_out = cur.pins.data;
    assign mem_data_oe_out = cur.pins.data_oe;
    assign mem_select_n_out = cur.pins.select_n;
    assign select_program_high_level_out = cur.pins.select_program_high_level;
    assign program_pulse_out = cur.pins.program_pulse;
endmodule
`default_nettype wire

/* uep_programmer_monitor.sv */
// port checks for the eprom controller
`timescale 1ns/10ps
`default_nettype none
module uep_programmer_monitor (
    input wire logic clk_in, rst_in, busy_out, done_out, mem_data_oe_out, mem_select_n_out,
    input wire logic select_program_high_level_out, program_pulse_out,
    input wire logic [9:0] mem_addr_out,
    input wire logic [7:0] mem_data_out, read_data_out, mem_data_in
);
    wire logic pl = program_pulse_out, hv = select_program_high_level_out, sn = mem_select_n_out;
    wire logic [9:0] ad = mem_addr_out;
    wire logic [7:0] dq = mem_data_out;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    a_pulse_level: assert property (pl |-> hv && sn && mem_data_oe_out) else $error("bad level");
    a_pulse_steady: assert property (pl && $past(pl) |-> $stable(ad) && $stable(dq)) else $error("pins moved");
    a_pulse_width: assert property ($rose(pl) |-> pl [*4] ##1 !pl) else $error("pulse width");
    a_exit_order: assert property ($fell(hv) |-> (!pl && $stable(ad)) [*8]) else $error("exit order");
    a_idle_quiet: assert property (!busy_out |-> !pl && !hv) else $error("idle drive");
    a_read_access: assert property ($fell(sn) |-> ##19 (done_out && read_data_out == $past(mem_data_in)))
        else $error("read timing");
    a_select_float: assert property (!sn |-> !hv && !mem_data_oe_out) else $error("read clash");
    a_done_pulse: assert property (done_out |=> !done_out) else $error("long done");
endmodule
bind uep_programmer uep_programmer_monitor uep_programmer_monitor_inst (.*);
`default_nettype wire

/* uep_eprom_model.sv */
// behavioural byte-wide uv prom
`timescale 1ns/10ps
`default_nettype none
module uep_eprom_model (
    input wire logic [9:0] mem_addr_out,
    input wire logic [7:0] mem_data_out,
    input wire logic mem_select_n_out, select_program_high_level_out, program_pulse_out,
    output logic [7:0] mem_data_in
);
    logic [7:0] mem [1024] = '{default: 8'hFF};
    int hits [1024] = '{default: 0}; // pulses per address
    // pulse under the high level only clears bits
    always @(posedge program_pulse_out) if (select_program_high_level_out) begin
        mem[mem_addr_out] &= mem_data_out;
        hits[mem_addr_out]++;
    end
    // static read; inverted when not read-selected
    wire logic rd = !mem_select_n_out && !select_program_high_level_out;
    assign mem_data_in = rd ? mem[mem_addr_out] : ~mem[mem_addr_out];
endmodule
`default_nettype wire

/* uep_programmer_tb_top.sv */
// bench: controller against a behavioural prom
`timescale 1ns/10ps
`default_nettype none
module uep_programmer_tb_top;
    logic clk_in = 1'b0, rst_in = 1'b1, read_req_in = 1'b0, prog_req_in = 1'b0;
    logic busy_out, done_out, mem_data_oe_out, mem_select_n_out, select_program_high_level_out, program_pulse_out;
    logic [9:0] read_addr_in = 10'h000, image_addr_out, mem_addr_out;
    logic [7:0] key = 8'h5A, d, image_data_in, read_data_out, mem_data_out, mem_data_in;
    int fails = 0, checks_done = 0, cyc = 0;
    assign image_data_in = image_addr_out[7:0] ^ key; // image byte per address
    always #12.5 clk_in = ~clk_in; // 40 MHz
    uep_programmer #(.WORDS(32), .PULSE_CYC(4), .LOOPS(2), .PW_MIN_CYC(4)) uep_programmer_inst (.*);
    uep_eprom_model uep_eprom_model_inst (.*);
    task automatic check(input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) fails++;
        if (seen !== exp) $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
    endtask
    task automatic give_verdict();
        $display("%0d checks %0d fails", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one request held for one edge, then wait for done
    task automatic request(input logic rd, input logic [9:0] a);
        @(negedge clk_in);
        {read_req_in, prog_req_in, read_addr_in} = {rd, ~rd, a};
        @(negedge clk_in);
        {read_req_in, prog_req_in} = 2'h0;
        while (done_out !== 1'b1) @(negedge clk_in);
        d = read_data_out;
    endtask
    // blank read, two runs, readback shows bits only clear
    task automatic t_program();
        request(1'b1, 10'h3FF);
        check(d, 8'hFF);
        check({7'h00, busy_out}, 8'h00);
        request(1'b0, 10'h000);
        check(8'(uep_eprom_model_inst.hits[31]), 8'h02);
        check(8'(uep_eprom_model_inst.hits[0]), 8'h02);
        request(1'b1, 10'h013);
        check(d, 8'h49);
        key = 8'hA5;
        request(1'b0, 10'h000);
        request(1'b1, 10'h013);
        check(d, 8'h00);
    endtask
    initial begin
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        t_program();
        give_verdict();
    end
    // hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 80000) fails++;
        if (cyc == 80000) give_verdict();
    end
endmodule
`default_nettype wire
